//--- sib_defines.vh
// constants for the status indicator and start-up strap block
`ifndef SIB_DEFINES_VH
`define SIB_DEFINES_VH

`define SIB_NUM_IO       11
`define SIB_CLK_HZ       200000000
`define SIB_MS_PER_S     1000
`define SIB_HOLD_S       10
`define SIB_FLASH_MS     100
`define SIB_SETTLE       2'h3

// register byte offsets
`define SIB_REG_CTRL     6'h00
`define SIB_REG_CFG      6'h04
`define SIB_REG_STATUS   6'h08
`define SIB_REG_IO_DIR   6'h0C
`define SIB_REG_IO_OUT   6'h10
`define SIB_REG_IO_PU    6'h14
`define SIB_REG_IO_PD    6'h18
`define SIB_REG_IO_IN    6'h1C

// control register fields
`define SIB_CTRL_MODE_LO 0
`define SIB_CTRL_MODE_HI 1
`define SIB_CTRL_EMUL    2
`define SIB_CTRL_LINK_LO 3
`define SIB_CTRL_LINK_HI 4
`define SIB_CTRL_BOND    5
`define SIB_CTRL_GAP     6
`define SIB_CTRL_ACT     8

// configuration register fields
`define SIB_CFG_DSR_LO   0
`define SIB_CFG_DSR_HI   2
`define SIB_CFG_DTR_LO   4
`define SIB_CFG_DTR_HI   5

// status register fields
`define SIB_ST_UART_DEF  0
`define SIB_ST_LOADER    1
`define SIB_ST_FACTORY   2
`define SIB_ST_HOLDING   3
`define SIB_ST_STARTED   4
`define SIB_ST_CONNABLE  5
`define SIB_ST_UART_EN   6
`define SIB_ST_SLEEP     7
`define SIB_ST_DSR       8

// operating modes
`define SIB_MODE_DATA    2'h0
`define SIB_MODE_EXT     2'h1
`define SIB_MODE_CMD     2'h2

// link states
`define SIB_LINK_IDLE    2'h0
`define SIB_LINK_CONNING 2'h1
`define SIB_LINK_CONNED  2'h2

// handshake input actions
`define SIB_DSR_NONE     3'h0
`define SIB_DSR_CMD      3'h1
`define SIB_DSR_DISC     3'h2
`define SIB_DSR_TOGGLE   3'h3
`define SIB_DSR_UART     3'h4
`define SIB_DSR_SLEEP    3'h5

// handshake output sources
`define SIB_DTR_MODE     2'h0
`define SIB_DTR_EMUL     2'h1
`define SIB_DTR_BOND     2'h2
`define SIB_DTR_GAP      2'h3

`endif

//--- sib_io_pad.v
// one user pin: direction, pulls and synchronised input
`timescale 1ns/1ps
module sib_io_pad (
  input  wire clk_sys,
  input  wire sys_rst,
  input  wire clr,
  input  wire dir_out,
  input  wire out_val,
  input  wire pull_up,
  input  wire pull_dn,
  input  wire pad_i,
  output reg  pad_o,
  output reg  pad_oe,
  output reg  pad_pu,
  output reg  pad_pd,
  output reg  in_val
);
  reg meta;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta   <= 1'b0;
      in_val <= 1'b0;
      pad_o  <= 1'b0;
      pad_oe <= 1'b0;
      pad_pu <= 1'b0;
      pad_pd <= 1'b0;
    end else if (clr) begin
      meta   <= 1'b0;
      in_val <= 1'b0;
      pad_o  <= 1'b0;
      pad_oe <= 1'b0;
      pad_pu <= 1'b0;
      pad_pd <= 1'b0;
    end else begin
      meta   <= pad_i;
      in_val <= meta;
      pad_o  <= out_val;
      pad_oe <= dir_out;
      pad_pu <= ~dir_out & pull_up;
      pad_pd <= ~dir_out & pull_dn & ~pull_up;
    end
  end
endmodule // sib_io_pad

//--- sib_partner.sv
// far side model: buttons, handshake line and user pins
`timescale 1ns/1ps
module sib_partner (
  input  wire        clk_sys,
  input  wire        press1,
  input  wire        press2,
  input  wire        dsr_on,
  input  wire [10:0] pad_o,
  input  wire [10:0] pad_oe,
  input  wire [10:0] pad_pu,
  input  wire [10:0] pad_pd,
  output wire        button1_n,
  output wire        button2_n,
  output wire        dsr_n,
  output wire [10:0] pad_i
);
  logic flt = 1'b0;
  // undriven pins without pulls change every cycle
  always @(posedge clk_sys) flt <= ~flt;
  assign button1_n = ~press1;
  assign button2_n = ~press2;
  assign dsr_n     = ~dsr_on;
  // pin level from drive and pulls
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & pad_pu) | (~pad_oe & ~pad_pu & ~pad_pd & {11{flt}});
endmodule // sib_partner

//--- sib_top.v
// status indicator, start-up straps, handshake pins and user pins
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "sib_defines.vh"
module sib_top #(
  parameter MS_CYCLES = `SIB_CLK_HZ / `SIB_MS_PER_S
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        reset_n_pin,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        button1_n,
  input  wire        button2_n,
  input  wire        dsr_n,
  output reg         dtr_n,
  output reg         led_red_n,
  output reg         led_green_n,
  output reg         led_blue_n,
  output reg         uart_defaults,
  output reg         factory_defaults,
  output reg         loader_mode,
  output reg         connect_req,
  output reg         cmd_mode_req,
  output reg         disconnect_req,
  output reg         connectable,
  output reg         uart_enable,
  output reg         sleep_mode,
  input  wire [10:0] io_pad_i,
  output wire [10:0] io_pad_o,
  output wire [10:0] io_pad_oe,
  output wire [10:0] io_pad_pu,
  output wire [10:0] io_pad_pd
);
  localparam HOLD_MS = `SIB_HOLD_S * `SIB_MS_PER_S;
  localparam [13:0] HOLD_CNT = HOLD_MS;
  localparam [7:0] FLASH_CNT = `SIB_FLASH_MS;
  localparam [7:0] FLASH_HALF = `SIB_FLASH_MS / 2;

  // synchronisers for pins
  reg        rstn_m, rstn_s;
  reg        b1_m, b1_s, b2_m, b2_s, dsr_m, dsr_s;
  wire       clr;

  // registers
  reg [1:0]  op_mode;
  reg        link_emul;
  reg [1:0]  link_state;
  reg        bonded, gap_link;
  reg [2:0]  dsr_cfg;
  reg [1:0]  dtr_cfg;
  reg [10:0] io_dir, io_out, io_pu, io_pd;
  wire [10:0] io_in;

  // start-up and hold state
  reg [1:0]  settle;
  reg        started;
  reg        holding;
  reg        uart_def_done, factory_done;
  reg [13:0] hold_ms;
  reg        b2_prev, dsr_prev;

  // millisecond divider and flash timer
  reg [17:0] ms_div;
  reg        ms_tick;
  reg [7:0]  flash;
  reg        act_pulse;

  wire       wb_req;
  wire [31:0] status;
  reg  [31:0] next_rd;

  assign clr = ~rstn_s;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rstn_m <= 1'b0;
      rstn_s <= 1'b0;
    end else begin
      rstn_m <= reset_n_pin;
      rstn_s <= rstn_m;
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      b1_m  <= 1'b1;
      b1_s  <= 1'b1;
      b2_m  <= 1'b1;
      b2_s  <= 1'b1;
      dsr_m <= 1'b1;
      dsr_s <= 1'b1;
    end else begin
      b1_m  <= button1_n;
      b1_s  <= b1_m;
      b2_m  <= button2_n;
      b2_s  <= b2_m;
      dsr_m <= dsr_n;
      dsr_s <= dsr_m;
    end
  end

  // millisecond enable pulse
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ms_div  <= 18'h00000;
      ms_tick <= 1'b0;
    end else if (clr) begin
      ms_div  <= 18'h00000;
      ms_tick <= 1'b0;
    end else if (ms_div == MS_CYCLES[17:0] - 18'h00001) begin
      ms_div  <= 18'h00000;
      ms_tick <= 1'b1;
    end else begin
      ms_div  <= ms_div + 18'h00001;
      ms_tick <= 1'b0;
    end
  end

  // start-up sampling, loader hold and connect request
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      settle           <= 2'h0;
      started          <= 1'b0;
      holding          <= 1'b0;
      hold_ms          <= 14'h0000;
      loader_mode      <= 1'b0;
      uart_def_done    <= 1'b0;
      factory_done     <= 1'b0;
      uart_defaults    <= 1'b0;
      factory_defaults <= 1'b0;
      connect_req      <= 1'b0;
      b2_prev          <= 1'b1;
    end else if (clr) begin
      settle           <= 2'h0;
      started          <= 1'b0;
      holding          <= 1'b0;
      hold_ms          <= 14'h0000;
      loader_mode      <= 1'b0;
      uart_def_done    <= 1'b0;
      factory_done     <= 1'b0;
      uart_defaults    <= 1'b0;
      factory_defaults <= 1'b0;
      connect_req      <= 1'b0;
      b2_prev          <= 1'b1;
    end else begin
      uart_defaults    <= 1'b0;
      factory_defaults <= 1'b0;
      connect_req      <= 1'b0;
      b2_prev          <= b2_s;
      if (!started) begin
        settle <= settle + 2'h1;
        if (settle == `SIB_SETTLE) begin
          started <= 1'b1;
          if (!b1_s && !b2_s) begin
            loader_mode <= 1'b1;
            holding     <= 1'b1;
            hold_ms     <= 14'h0000;
          end else if (b1_s && !b2_s) begin
            uart_defaults <= 1'b1;
            uart_def_done <= 1'b1;
          end
        end
      end else if (holding) begin
        if (b1_s || b2_s) begin
          holding <= 1'b0;
        end else if (hold_ms == HOLD_CNT) begin
          holding          <= 1'b0;
          loader_mode      <= 1'b0;
          factory_defaults <= 1'b1;
          factory_done     <= 1'b1;
        end else if (ms_tick) begin
          hold_ms <= hold_ms + 14'h0001;
        end
      end else if (!loader_mode && b2_prev && !b2_s) begin
        connect_req <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dsr_prev       <= 1'b1;
      cmd_mode_req   <= 1'b0;
      disconnect_req <= 1'b0;
      connectable    <= 1'b1;
      uart_enable    <= 1'b1;
      sleep_mode     <= 1'b0;
    end else if (clr) begin
      dsr_prev       <= 1'b1;
      cmd_mode_req   <= 1'b0;
      disconnect_req <= 1'b0;
      connectable    <= 1'b1;
      uart_enable    <= 1'b1;
      sleep_mode     <= 1'b0;
    end else begin
      dsr_prev       <= dsr_s;
      cmd_mode_req   <= 1'b0;
      disconnect_req <= 1'b0;
      case (dsr_cfg)
        `SIB_DSR_CMD: begin
          cmd_mode_req <= dsr_prev & ~dsr_s;
        end
        `SIB_DSR_DISC: begin
          disconnect_req <= dsr_prev & ~dsr_s;
        end
        `SIB_DSR_TOGGLE: begin
          if (dsr_prev && !dsr_s)
            connectable <= ~connectable;
        end
        `SIB_DSR_UART: begin
          uart_enable <= ~dsr_s;
        end
        `SIB_DSR_SLEEP: begin
          sleep_mode <= dsr_s;
        end
        default: begin
          uart_enable <= 1'b1;
        end
      endcase
    end
  end

  // indicator flash timer and outputs
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flash       <= 8'h00;
      led_red_n   <= 1'b1;
      led_green_n <= 1'b1;
      led_blue_n  <= 1'b1;
      dtr_n       <= 1'b1;
    end else if (clr) begin
      flash       <= 8'h00;
      led_red_n   <= 1'b1;
      led_green_n <= 1'b1;
      led_blue_n  <= 1'b1;
      dtr_n       <= 1'b1;
    end else begin
      if (act_pulse)
        flash <= FLASH_CNT;
      else if (ms_tick && flash != 8'h00)
        flash <= flash - 8'h01;
      if (link_emul && link_state == `SIB_LINK_CONNED) begin
        led_red_n   <= 1'b1;
        led_green_n <= 1'b1;
        led_blue_n  <= (flash > FLASH_HALF);
      end else if (link_emul && link_state == `SIB_LINK_CONNING) begin
        led_red_n   <= 1'b0;
        led_green_n <= 1'b1;
        led_blue_n  <= 1'b0;
      end else if (op_mode == `SIB_MODE_CMD) begin
        led_red_n   <= 1'b0;
        led_green_n <= 1'b0;
        led_blue_n  <= 1'b1;
      end else begin
        led_red_n   <= 1'b1;
        led_green_n <= 1'b0;
        led_blue_n  <= 1'b1;
      end
      case (dtr_cfg)
        `SIB_DTR_MODE: dtr_n <= ~(op_mode == `SIB_MODE_CMD);
        `SIB_DTR_EMUL: dtr_n <= ~(link_emul && link_state == `SIB_LINK_CONNED);
        `SIB_DTR_BOND: dtr_n <= ~bonded;
        default:       dtr_n <= ~gap_link;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SIB_NUM_IO; gi = gi + 1) begin : g_io
      sib_io_pad u_pad (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clr     (clr),
        .dir_out (io_dir[gi]),
        .out_val (io_out[gi]),
        .pull_up (io_pu[gi]),
        .pull_dn (io_pd[gi]),
        .pad_i   (io_pad_i[gi]),
        .pad_o   (io_pad_o[gi]),
        .pad_oe  (io_pad_oe[gi]),
        .pad_pu  (io_pad_pu[gi]),
        .pad_pd  (io_pad_pd[gi]),
        .in_val  (io_in[gi])
      );
    end
  endgenerate

  // wishbone slave
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  assign status = {23'h000000, dsr_s, sleep_mode, uart_enable, connectable,
                   started, holding, factory_done, loader_mode, uart_def_done};

  always @* begin
    case (wb_adr_i)
      `SIB_REG_CTRL:   next_rd = {25'h0000000, gap_link, bonded, link_state,
                                  link_emul, op_mode};
      `SIB_REG_CFG:    next_rd = {26'h0000000, dtr_cfg, 1'b0, dsr_cfg};
      `SIB_REG_STATUS: next_rd = status;
      `SIB_REG_IO_DIR: next_rd = {21'h000000, io_dir};
      `SIB_REG_IO_OUT: next_rd = {21'h000000, io_out};
      `SIB_REG_IO_PU:  next_rd = {21'h000000, io_pu};
      `SIB_REG_IO_PD:  next_rd = {21'h000000, io_pd};
      `SIB_REG_IO_IN:  next_rd = {21'h000000, io_in};
      default:         next_rd = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      op_mode    <= `SIB_MODE_DATA;
      link_emul  <= 1'b0;
      link_state <= `SIB_LINK_IDLE;
      bonded     <= 1'b0;
      gap_link   <= 1'b0;
      dsr_cfg    <= `SIB_DSR_NONE;
      dtr_cfg    <= `SIB_DTR_MODE;
      io_dir     <= 11'h000;
      io_out     <= 11'h000;
      io_pu      <= 11'h000;
      io_pd      <= 11'h000;
      act_pulse  <= 1'b0;
    end else if (clr) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      op_mode    <= `SIB_MODE_DATA;
      link_emul  <= 1'b0;
      link_state <= `SIB_LINK_IDLE;
      bonded     <= 1'b0;
      gap_link   <= 1'b0;
      dsr_cfg    <= `SIB_DSR_NONE;
      dtr_cfg    <= `SIB_DTR_MODE;
      io_dir     <= 11'h000;
      io_out     <= 11'h000;
      io_pu      <= 11'h000;
      io_pd      <= 11'h000;
      act_pulse  <= 1'b0;
    end else begin
      wb_ack_o  <= wb_req;
      act_pulse <= 1'b0;
      if (wb_req && !wb_we_i)
        wb_dat_o <= next_rd;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `SIB_REG_CTRL: begin
            if (wb_sel_i[0]) begin
              op_mode    <= wb_dat_i[`SIB_CTRL_MODE_HI:`SIB_CTRL_MODE_LO];
              link_emul  <= wb_dat_i[`SIB_CTRL_EMUL];
              link_state <= wb_dat_i[`SIB_CTRL_LINK_HI:`SIB_CTRL_LINK_LO];
              bonded     <= wb_dat_i[`SIB_CTRL_BOND];
              gap_link   <= wb_dat_i[`SIB_CTRL_GAP];
            end
            if (wb_sel_i[1])
              act_pulse <= wb_dat_i[`SIB_CTRL_ACT];
          end
          `SIB_REG_CFG: begin
            if (wb_sel_i[0]) begin
              dsr_cfg <= wb_dat_i[`SIB_CFG_DSR_HI:`SIB_CFG_DSR_LO];
              dtr_cfg <= wb_dat_i[`SIB_CFG_DTR_HI:`SIB_CFG_DTR_LO];
            end
          end
          `SIB_REG_IO_DIR: begin
            if (wb_sel_i[0]) io_dir[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) io_dir[10:8] <= wb_dat_i[10:8];
          end
          `SIB_REG_IO_OUT: begin
            if (wb_sel_i[0]) io_out[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) io_out[10:8] <= wb_dat_i[10:8];
          end
          `SIB_REG_IO_PU: begin
            if (wb_sel_i[0]) io_pu[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) io_pu[10:8] <= wb_dat_i[10:8];
          end
          `SIB_REG_IO_PD: begin
            if (wb_sel_i[0]) io_pd[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) io_pd[10:8] <= wb_dat_i[10:8];
          end
          default: begin
            act_pulse <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // sib_top

//--- sib_top_properties.sv
// concurrent checks on the status and strap block ports
`timescale 1ns/1ps
module sib_checker #(
  parameter MS_CYCLES = 1
) (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        reset_n_pin,
  input wire        button1_n,
  input wire        button2_n,
  input wire        dsr_n,
  input wire        dtr_n,
  input wire        led_red_n,
  input wire        led_green_n,
  input wire        led_blue_n,
  input wire        uart_defaults,
  input wire        factory_defaults,
  input wire        loader_mode,
  input wire        connect_req,
  input wire        cmd_mode_req,
  input wire        disconnect_req,
  input wire [10:0] io_pad_oe,
  input wire [10:0] io_pad_pu,
  input wire [10:0] io_pad_pd
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_both;
    !button1_n && !button2_n;
  endsequence
  sequence s_gone(x);
    ##1 !x;
  endsequence
  property p_rst_out;
    !reset_n_pin [*4] |=> led_red_n && led_green_n && led_blue_n && dtr_n;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  property p_led_legal;
    {led_red_n, led_green_n, led_blue_n} inside {3'h7, 3'h5, 3'h1, 3'h2, 3'h6};
  endproperty
  a_led_legal: assert property (p_led_legal) else $error("bad colour");
  property p_fac;
    factory_defaults |-> s_both ##1 !factory_defaults && !loader_mode;
  endproperty
  a_fac: assert property (p_fac) else $error("bad factory restore");
  property p_loader;
    $rose(loader_mode) |-> s_both;
  endproperty
  a_loader: assert property (p_loader) else $error("bad loader entry");
  property p_uart_def;
    uart_defaults |-> button1_n && !button2_n && !loader_mode ##0 s_gone(uart_defaults);
  endproperty
  a_uart_def: assert property (p_uart_def) else $error("bad uart restore");
  property p_conn;
    connect_req |-> !button2_n && !loader_mode ##0 s_gone(connect_req);
  endproperty
  a_conn: assert property (p_conn) else $error("bad connect request");
  property p_dsr;
    cmd_mode_req || disconnect_req |-> !dsr_n;
  endproperty
  a_dsr: assert property (p_dsr) else $error("pulse without handshake");
  property p_pull;
    ((io_pad_pu | io_pad_pd) & io_pad_oe) == 11'h000 && (io_pad_pu & io_pad_pd) == 11'h000;
  endproperty
  a_pull: assert property (p_pull) else $error("bad pull setting");
endmodule // sib_checker

//--- sib_top_test.sv
// self-checking bench for the status and strap block
`timescale 1ns/1ps
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module sib_top_test;
  localparam MS = 1;
  logic clk_sys = 0, sys_rst = 1, reset_n_pin = 1, cyc = 0, stb = 0, we = 0;
  logic [5:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rdat;
  logic p1 = 0, p2 = 0, dsr_on = 0;
  wire [31:0] dato;
  wire ack, b1, b2, dsr_n, dtr_n, lr, lg, lb, ud, fd, ldr, cr, cm, dc, conn, uen, slp;
  wire [10:0] pi, po, poe, ppu, ppd;
  int fails = 0, tests_run = 0, n_ud = 0, n_fd = 0, n_cr = 0, n_cm = 0, n_dc = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n_ud <= n_ud + (ud === 1'b1);
    n_fd <= n_fd + (fd === 1'b1);
    n_cr <= n_cr + (cr === 1'b1);
    n_cm <= n_cm + (cm === 1'b1);
    n_dc <= n_dc + (dc === 1'b1);
  end
  sib_top #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_n_pin(reset_n_pin),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .button1_n(b1), .button2_n(b2),
    .dsr_n(dsr_n), .dtr_n(dtr_n), .led_red_n(lr), .led_green_n(lg), .led_blue_n(lb),
    .uart_defaults(ud), .factory_defaults(fd), .loader_mode(ldr), .connect_req(cr),
    .cmd_mode_req(cm), .disconnect_req(dc), .connectable(conn), .uart_enable(uen),
    .sleep_mode(slp), .io_pad_i(pi), .io_pad_o(po), .io_pad_oe(poe), .io_pad_pu(ppu),
    .io_pad_pd(ppd));
  sib_partner pm (.clk_sys(clk_sys), .press1(p1), .press2(p2), .dsr_on(dsr_on), .pad_o(po),
    .pad_oe(poe), .pad_pu(ppu), .pad_pd(ppd), .button1_n(b1), .button2_n(b2), .dsr_n(dsr_n),
    .pad_i(pi));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 50);
    rdat = dato;
    if (n >= 50) fails++;
    cyc <= 0; stb <= 0;
  endtask
  task automatic restart(input logic a, input logic b);
    @(posedge clk_sys);
    p1 <= a; p2 <= b; reset_n_pin <= 0;
    tick(6);
    `CHK("rst_out", 4'hF, {lr, lg, lb, dtr_n})
    reset_n_pin <= 1;
    tick(20);
  endtask
  task automatic test_leds;
    logic [8:0] c [6] = '{9'h000, 9'h001, 9'h002, 9'h00C, 9'h014, 9'h012};
    logic [2:0] e [6] = '{3'h5, 3'h5, 3'h1, 3'h2, 3'h6, 3'h1};
    for (int i = 0; i < 6; i++) begin
      wb(1, 6'h00, {23'h0, c[i]}); tick(3);
      `CHK("leds", e[i], {lr, lg, lb})
    end
    wb(1, 6'h00, 32'h008); tick(3);
    `CHK("non_emul", 3'h5, {lr, lg, lb})
    wb(1, 6'h00, 32'h014); tick(3);
    `CHK("blue_lit", 1'b0, lb)
    wb(1, 6'h00, 32'h114); tick(10);
    `CHK("flash", 1'b1, lb)
    tick(150);
    `CHK("steady", 1'b0, lb)
    $display("test leds done");
  endtask
  task automatic test_dsr;
    int c0, c1;
    logic k;
    logic [31:0] dv [4] = '{32'h02, 32'h14, 32'h20, 32'h40};
    for (int a = 1; a < 6; a++) begin
      wb(1, 6'h04, 32'(a)); c0 = n_cm; c1 = n_dc; k = conn;
      dsr_on <= 1; tick(8);
      case (a)
        1: `CHK("cmd", c0 + 1, n_cm)
        2: `CHK("disc", c1 + 1, n_dc)
        3: `CHK("toggle", ~k, conn)
        4: `CHK("uart_on", 1'b1, uen)
        default: `CHK("awake", 1'b0, slp)
      endcase
      dsr_on <= 0; tick(8);
      if (a == 4) `CHK("uart_off", 1'b0, uen)
      if (a == 5) `CHK("asleep", 1'b1, slp)
    end
    for (int i = 0; i < 4; i++) begin
      wb(1, 6'h04, 32'(i << 4)); wb(1, 6'h00, dv[i]); tick(3);
      `CHK("dtr_on", 1'b0, dtr_n)
      wb(1, 6'h00, 32'h0); tick(3);
      `CHK("dtr_off", 1'b1, dtr_n)
    end
    $display("test handshake done");
  endtask
  task automatic test_io;
    wb(1, 6'h0C, 32'h00F); wb(1, 6'h10, 32'h005);
    wb(1, 6'h14, 32'h0F0); wb(1, 6'h18, 32'h300); tick(3);
    `CHK("oe", 11'h00F, poe)
    `CHK("drive", 11'h005, po & 11'h00F)
    `CHK("pulls", {11'h0F0, 11'h300}, {ppu, ppd})
    wb(0, 6'h1C, 32'h0);
    `CHK("pins_in", 10'h0F5, rdat[9:0])
    wb(0, 6'h20, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    $display("test pins done");
  endtask
  task automatic test_uart;
    int c, u;
    wb(1, 6'h00, 32'h016);
    u = n_ud;
    restart(1'b0, 1'b1);
    `CHK("uart_def", u + 1, n_ud)
    wb(0, 6'h00, 32'h0);
    `CHK("ctrl_clr", 32'h0, rdat)
    p2 <= 0; tick(10); c = n_cr;
    p2 <= 1; tick(10);
    `CHK("conn_req", c + 1, n_cr)
    `CHK("no_resample", u + 1, n_ud)
    p2 <= 0; tick(5);
    $display("test uart restore done");
  endtask
  task automatic test_loader;
    int c, n;
    c = n_fd;
    restart(1'b1, 1'b1);
    `CHK("loader", 1'b1, ldr)
    n = 0;
    while (n_fd == c && n < 12000) begin @(posedge clk_sys); n++; end
    `CHK("hold_len", 1'b1, n > 9900 && n < 10010)
    tick(2);
    `CHK("loader_off", 1'b0, ldr)
    p1 <= 0; p2 <= 0; tick(5);
    $display("test loader done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    tick(20);
    sys_rst <= 0;
    tick(10);
    test_leds; test_dsr; test_io; test_uart; test_loader;
    final_report;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    final_report;
  end
endmodule // sib_top_test
bind sib_top sib_checker #(.MS_CYCLES(MS_CYCLES)) chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reset_n_pin(reset_n_pin), .button1_n(button1_n), .button2_n(button2_n), .dsr_n(dsr_n),
  .dtr_n(dtr_n), .led_red_n(led_red_n), .led_green_n(led_green_n), .led_blue_n(led_blue_n),
  .uart_defaults(uart_defaults), .factory_defaults(factory_defaults),
  .loader_mode(loader_mode), .connect_req(connect_req), .cmd_mode_req(cmd_mode_req),
  .disconnect_req(disconnect_req), .io_pad_oe(io_pad_oe), .io_pad_pu(io_pad_pu),
  .io_pad_pd(io_pad_pd));
